// ---- rtl/pes_pkg.sv ----
// Constants for the bus-side error status and reporting block.
// Assumes a single bus clock domain and bus reset as the only reset.
`default_nettype none

package pes_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Field widths
  localparam int HOST_W = 16; // Host status word width
  localparam int PCIX_W = 32; // PCI-X status word width
  localparam int DMA_W = 8; // Each DMA status register width
  localparam int NUM_DMA = 3; // Channel 0, channel 1, direct port

  ////////////////////////////////////////////////////////////////////////////
  // Host status word bit positions
  localparam int HS_MASTER_PERR = 8; // Master parity error
  localparam int HS_MASTER_ABORT = 13; // Received master-abort
  localparam int HS_SERR_SENT = 14; // System error asserted
  localparam int HS_DET_PERR = 15; // Detected parity error

  // PCI-X status word bit position
  localparam int PX_RX_SCE_MSG = 29; // Received split completion error msg

  // DMA status register bit positions
  localparam int DS_ACTIVE = 0; // DMA active
  localparam int DS_ERROR = 1; // DMA error

  // DMA register indices within the status vector
  localparam int DMA_IDE0 = 0; // IDE channel 0
  localparam int DMA_IDE1 = 1; // IDE channel 1
  localparam int DMA_DIRECT = 2; // Direct port access register

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [15:0] HOST_RST = 16'h0000;
  localparam logic [31:0] PCIX_RST = 32'h0000_0000;
  localparam logic [7:0] DMA_RST = 8'h00;

  // Parity error pin driver states
  typedef enum logic [1:0] {
    PES_PERR_IDLE,
    PES_PERR_LOW,
    PES_PERR_HIGH
  } pes_perr_state_t;

endpackage : pes_pkg

`default_nettype wire

// ---- rtl/pes_error_status.sv ----
// Bus-side error reporting: parity pins, status words, DMA stop on error.
// Assumes same-clock one-cycle event pulses from the bus interface logic,
// mode inputs that are static or on clk_i, and software clears as
// write-one-to-clear masks held for one cycle.
`default_nettype none

module pes_error_status #(
  parameter int DMA_STAT_W = pes_pkg::DMA_W // DMA status register width
) (
  input wire logic clk_i, // Bus clock
  input wire logic nrst_i, // Bus reset, active low
  // Mode and configuration levels
  input wire logic pcix_mode_i, // High in PCI-X mode, low in PCI
  input wire logic direct_port_access_mode_i, // High: direct DMA register
  input wire logic split_completion_error_enable_i, // Split msg reporting
  input wire logic ide_chan_sel_i, // IDE channel owning the DMA
  // Error events from the bus interface, one-cycle pulses
  input wire logic ob_wr_watch_i, // Our outbound write data phase open
  input wire logic ob_wr_msi_i, // That outbound write is an MSI
  input wire logic ib_wr_perr_i, // Data parity error on inbound write
  input wire logic scm_perr_i, // Parity error in split completion msg
  input wire logic ob_rd_mabort_i, // Outbound read ended in master-abort
  // DMA engine control, one-cycle pulses per register
  input wire logic [pes_pkg::NUM_DMA-1:0] dma_start_i, // Set active
  input wire logic [pes_pkg::NUM_DMA-1:0] dma_done_i, // Normal finish
  // Software clears, write-one-to-clear
  input wire logic [pes_pkg::HOST_W-1:0] host_clr_i, // Host word clear
  input wire logic [pes_pkg::PCIX_W-1:0] pcix_clr_i, // PCI-X word clear
  input wire logic [pes_pkg::NUM_DMA-1:0] dma_err_clr_i, // DMA error clear
  // PERR# two-way pin
  input wire logic perr_n_i, // Pin level
  output logic perr_n_o, // Driven value
  output logic perr_oe_n_o, // Low while driving
  // SERR# open-drain pin
  input wire logic serr_n_i, // Pin level
  output logic serr_n_o, // Driven value, always low when enabled
  output logic serr_oe_n_o, // Low while pulling low
  // Status words
  output logic [pes_pkg::HOST_W-1:0] host_status_word_o, // Host status
  output logic [pes_pkg::PCIX_W-1:0] pcix_status_word_o, // PCI-X status
  output logic [DMA_STAT_W-1:0] ide_chan0_dma_status_o, // IDE ch0
  output logic [DMA_STAT_W-1:0] ide_chan1_dma_status_o, // IDE ch1
  output logic [DMA_STAT_W-1:0] direct_dma_status_o, // Direct DMA
  output logic serr_seen_o // Registered: SERR# seen low on the bus
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic perr_sync1; // First stage, read only by the second
  logic perr_sync2; // Second stage, usable
  logic perr_sync3; // Delayed copy for edge detection
  logic serr_sync1; // First stage
  logic serr_sync2; // Second stage

  // Two flops before any logic looks at a pin
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      perr_sync1 <= 1'b1;
      perr_sync2 <= 1'b1;
      perr_sync3 <= 1'b1;
      serr_sync1 <= 1'b1;
      serr_sync2 <= 1'b1;
    end else begin
      perr_sync1 <= perr_n_i;
      perr_sync2 <= perr_sync1;
      perr_sync3 <= perr_sync2;
      serr_sync1 <= serr_n_i;
      serr_sync2 <= serr_sync1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event decode

  logic ob_wr_perr; // Target reported parity against our write
  logic scm_err; // Split message parity, PCI-X only
  logic dma_err; // Any error that stops the owning DMA
  logic drive_perr; // Request to pulse PERR#
  logic drive_serr; // Request to pulse SERR#
  logic [pes_pkg::NUM_DMA-1:0] dma_hit; // One-hot owning register

  // Combine raw events into pin requests and DMA stop
  always_comb begin
    // Falling edge of the target's PERR# during our write data phase
    ob_wr_perr = ob_wr_watch_i & ~perr_sync2 & perr_sync3;
    scm_err = scm_perr_i & pcix_mode_i;
    // Inbound write parity is not a DMA fault; the other three are
    dma_err = ob_wr_perr | scm_err | ob_rd_mabort_i;
    drive_perr = ib_wr_perr_i | scm_err;
    // Outbound write parity raises SERR# only in PCI-X or for MSI
    drive_serr = (ob_wr_perr & (pcix_mode_i | ob_wr_msi_i))
      | scm_err;
    // Master-abort on a read drives neither pin
    dma_hit = '0;
    if (direct_port_access_mode_i) begin
      dma_hit[pes_pkg::DMA_DIRECT] = 1'b1;
    end else if (ide_chan_sel_i) begin
      dma_hit[pes_pkg::DMA_IDE1] = 1'b1;
    end else begin
      dma_hit[pes_pkg::DMA_IDE0] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PERR# driver: one clock low, one clock high, then released

  pes_pkg::pes_perr_state_t perr_state; // Current driver state
  pes_pkg::pes_perr_state_t next_perr_state; // Next driver state
  logic perr_n; // Registered pin value
  logic next_perr_n; // Next pin value
  logic perr_oe_n; // Registered enable
  logic next_perr_oe_n; // Next enable

  // Next state for the PERR# pulse
  always_comb begin
    next_perr_state = perr_state;
    next_perr_n = 1'b1;
    next_perr_oe_n = 1'b1;
    case (perr_state)
      // Idle: start a pulse on request
      pes_pkg::PES_PERR_IDLE: begin
        if (drive_perr) begin
          next_perr_state = pes_pkg::PES_PERR_LOW;
          next_perr_n = 1'b0;
          next_perr_oe_n = 1'b0;
        end
      end
      // Low: restore high so the shared line is not left floating low
      pes_pkg::PES_PERR_LOW: begin
        next_perr_state = pes_pkg::PES_PERR_HIGH;
        next_perr_n = 1'b1;
        next_perr_oe_n = 1'b0;
      end
      // High: release, or pulse again straight away
      pes_pkg::PES_PERR_HIGH: begin
        if (drive_perr) begin
          next_perr_state = pes_pkg::PES_PERR_LOW;
          next_perr_n = 1'b0;
          next_perr_oe_n = 1'b0;
        end else begin
          next_perr_state = pes_pkg::PES_PERR_IDLE;
        end
      end
      // Recover from an illegal code
      default: begin
        next_perr_state = pes_pkg::PES_PERR_IDLE;
      end
    endcase
  end

  // Register the PERR# driver
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      perr_state <= pes_pkg::PES_PERR_IDLE;
      perr_n <= 1'b1;
      perr_oe_n <= 1'b1;
    end else begin
      perr_state <= next_perr_state;
      perr_n <= next_perr_n;
      perr_oe_n <= next_perr_oe_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // SERR# driver: open drain, pulled low for one clock per request

  logic serr_oe_n; // Registered enable
  logic next_serr_oe_n; // Next enable
  logic serr_seen; // Sticky copy of SERR# seen low
  logic next_serr_seen; // Next sticky copy

  // Next SERR# enable and observation flag
  always_comb begin
    next_serr_oe_n = ~drive_serr;
    next_serr_seen = serr_seen | ~serr_sync2;
  end

  // Register the SERR# driver
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      serr_oe_n <= 1'b1;
      serr_seen <= 1'b0;
    end else begin
      serr_oe_n <= next_serr_oe_n;
      serr_seen <= next_serr_seen;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status words: set wins over a software clear in the same cycle

  logic [pes_pkg::HOST_W-1:0] host_status; // Host status word
  logic [pes_pkg::HOST_W-1:0] next_host_status; // Next host word
  logic [pes_pkg::HOST_W-1:0] host_set; // Bits to set now
  logic [pes_pkg::PCIX_W-1:0] pcix_status; // PCI-X status word
  logic [pes_pkg::PCIX_W-1:0] next_pcix_status; // Next PCI-X word
  logic [pes_pkg::PCIX_W-1:0] pcix_set; // Bits to set now

  // Next values of the two bus status words
  always_comb begin
    host_set = '0;
    host_set[pes_pkg::HS_MASTER_PERR] = ob_wr_perr
      | scm_err;
    host_set[pes_pkg::HS_MASTER_ABORT] = ob_rd_mabort_i;
    host_set[pes_pkg::HS_SERR_SENT] = drive_serr;
    host_set[pes_pkg::HS_DET_PERR] = drive_perr;
    pcix_set = '0;
    pcix_set[pes_pkg::PX_RX_SCE_MSG] = scm_err
      & split_completion_error_enable_i;
    // Sticky until cleared; a new event beats the clear
    next_host_status = (host_status & ~host_clr_i) | host_set;
    next_pcix_status = (pcix_status & ~pcix_clr_i) | pcix_set;
  end

  // Register the status words, cleared by bus reset
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      host_status <= pes_pkg::HOST_RST;
      pcix_status <= pes_pkg::PCIX_RST;
    end else begin
      host_status <= next_host_status;
      pcix_status <= next_pcix_status;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // DMA status registers, one per owner

  logic [DMA_STAT_W-1:0] dma_status [pes_pkg::NUM_DMA]; // Current values
  logic [DMA_STAT_W-1:0] next_dma_status [pes_pkg::NUM_DMA]; // Next values

  for (genvar g = 0; g < pes_pkg::NUM_DMA; g++) begin : g_dma
    logic stop; // Error lands on this register

    // Next active and error bits; the error stops the transfer
    always_comb begin
      stop = dma_err & dma_hit[g];
      next_dma_status[g] = dma_status[g];
      // Error beats a start or done in the same cycle
      if (stop) begin
        next_dma_status[g][pes_pkg::DS_ACTIVE] = 1'b0;
      end else if (dma_start_i[g]) begin
        next_dma_status[g][pes_pkg::DS_ACTIVE] = 1'b1;
      end else if (dma_done_i[g]) begin
        next_dma_status[g][pes_pkg::DS_ACTIVE] = 1'b0;
      end
      // Error flag: set wins over clear
      next_dma_status[g][pes_pkg::DS_ERROR] = stop
        | (dma_status[g][pes_pkg::DS_ERROR] & ~dma_err_clr_i[g]);
    end

    // Register this DMA status
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        dma_status[g] <= DMA_STAT_W'(pes_pkg::DMA_RST);
      end else begin
        dma_status[g] <= next_dma_status[g];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flops except serr_n_o, which is tied low

  assign perr_n_o = perr_n;
  assign perr_oe_n_o = perr_oe_n;
  assign serr_n_o = 1'b0;
  assign serr_oe_n_o = serr_oe_n;
  assign host_status_word_o = host_status;
  assign pcix_status_word_o = pcix_status;
  assign ide_chan0_dma_status_o = dma_status[pes_pkg::DMA_IDE0];
  assign ide_chan1_dma_status_o = dma_status[pes_pkg::DMA_IDE1];
  assign direct_dma_status_o = dma_status[pes_pkg::DMA_DIRECT];
  assign serr_seen_o = serr_seen;

endmodule : pes_error_status

`default_nettype wire

// ---- verif/pes_error_status_props.sv ----
// Checker: error status relations at the error block's ports.
// Assumes one clock domain and nrst_i as the only reset.
`default_nettype none

module pes_error_status_props (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic pcix_mode_i,
  input wire logic direct_port_access_mode_i,
  input wire logic split_completion_error_enable_i,
  input wire logic ide_chan_sel_i,
  input wire logic ob_wr_watch_i,
  input wire logic ib_wr_perr_i,
  input wire logic scm_perr_i,
  input wire logic ob_rd_mabort_i,
  input wire logic [15:0] host_clr_i,
  input wire logic perr_n_o,
  input wire logic perr_oe_n_o,
  input wire logic serr_oe_n_o,
  input wire logic [15:0] host_status_word_o,
  input wire logic [31:0] pcix_status_word_o,
  input wire logic [7:0] ide_chan0_dma_status_o,
  input wire logic [7:0] ide_chan1_dma_status_o,
  input wire logic [7:0] direct_dma_status_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic scm_hit; // Split message parity while in PCI-X mode
  logic stp; // A DMA-stopping event this cycle

  // Events that the block must turn into a DMA stop
  assign scm_hit = scm_perr_i & pcix_mode_i;
  assign stp = ob_rd_mabort_i | scm_hit;

  // One clock and one reset for every property below
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  ////////////////////////////////////////
  // Pin behaviour
  a_inbound_perr: assert property (
    ib_wr_perr_i && perr_oe_n_o |=>
    host_status_word_o[15] && !perr_oe_n_o && !perr_n_o)
    else $error("inbound parity not reported");
  a_perr_pulse_shape: assert property (
    $fell(perr_oe_n_o) |-> !perr_n_o ##1 perr_n_o && !perr_oe_n_o)
    else $error("PERR low pulse malformed");
  a_mabort_quiet: assert property (
    ob_rd_mabort_i && !ib_wr_perr_i && !scm_hit && !ob_wr_watch_i &&
    perr_oe_n_o && serr_oe_n_o |=> perr_oe_n_o && serr_oe_n_o)
    else $error("master-abort drove an error pin");

  ////////////////////////////////////////
  // Status words
  a_split_pcix_bits: assert property (
    scm_hit |=> host_status_word_o[15:14] == 2'h3 &&
    host_status_word_o[8] && !serr_oe_n_o)
    else $error("split message error bits missing");
  a_split_sce_bit: assert property (
    scm_hit && split_completion_error_enable_i |=> pcix_status_word_o[29])
    else $error("bit 29 not set");
  a_mabort_bit: assert property (
    ob_rd_mabort_i |=> host_status_word_o[13])
    else $error("master-abort bit not set");
  a_serr_flag_set: assert property (
    !serr_oe_n_o |-> host_status_word_o[14])
    else $error("SERR without bit 14");
  a_status_sticky: assert property (
    host_status_word_o[15] && !host_clr_i[15] |=> host_status_word_o[15])
    else $error("flag lost");

  ////////////////////////////////////////
  // DMA stop on the owning register
  a_direct_stop: assert property (
    stp && direct_port_access_mode_i |=> direct_dma_status_o[1:0] == 2'h2)
    else $error("direct DMA not stopped");
  a_ide_chan_stop: assert property (
    stp && !direct_port_access_mode_i |=>
    ($past(ide_chan_sel_i) ? ide_chan1_dma_status_o[1:0] :
    ide_chan0_dma_status_o[1:0]) == 2'h2)
    else $error("IDE DMA not stopped");
endmodule // pes_error_status_props

bind pes_error_status pes_error_status_props pes_error_status_props_i (
  .clk_i, .nrst_i, .pcix_mode_i, .direct_port_access_mode_i,
  .split_completion_error_enable_i, .ide_chan_sel_i, .ob_wr_watch_i,
  .ib_wr_perr_i,
  .scm_perr_i, .ob_rd_mabort_i, .host_clr_i, .perr_n_o, .perr_oe_n_o,
  .serr_oe_n_o, .host_status_word_o, .pcix_status_word_o,
  .ide_chan0_dma_status_o, .ide_chan1_dma_status_o, .direct_dma_status_o);

`default_nettype wire

// ---- verif/pes_bus_agent.sv ----
// Far-side target: flags our write data by pulling PERR# low.
// Assumes pull-ups on the shared PERR# and SERR# lines.
`default_nettype none

module pes_bus_agent (
  input wire logic clk_i,
  input wire logic flag_i, // Report a data parity error now
  input wire logic dut_perr_n_i, // Block's PERR# value
  input wire logic dut_perr_oe_n_i, // Block drives PERR# when low
  input wire logic dut_serr_n_i, // Block's SERR# value
  input wire logic dut_serr_oe_n_i, // Block pulls SERR# when low
  output logic perr_line_o, // Resolved PERR# level
  output logic serr_line_o // Resolved SERR# level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] st = 2'h0; // 0 released, 1 low, 2 restore high
  // Low one cycle, high one cycle, then release to the pull-up
  always_ff @(posedge clk_i) begin
    st <= flag_i ? 2'h1 : (st == 2'h1 ? 2'h2 : 2'h0);
  end
  assign perr_line_o = !dut_perr_oe_n_i ? dut_perr_n_i : (st != 2'h1);
  assign serr_line_o = dut_serr_oe_n_i ? 1'b1 : dut_serr_n_i;
endmodule // pes_bus_agent

`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench for the bus-side error status block.
// Assumes the far-side agent model and the bound checker.
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0; // Bus clock
  logic nrst_i = 1'b0; // Bus reset
  // Mode levels, event pulses and scan flags driven by the bench
  logic pcix, direct_port_access_mode, split_completion_error_enable, isel, wwatch, wmsi, ibp, scm, mab, flag, hit, saw;
  logic [2:0] start, done, dclr;
  logic [15:0] hclr, host, eh;
  logic [31:0] pclr, pcw, ep, rnd;
  logic perr_n, perr_oe_n, serr_n, serr_oe_n, perr_w, serr_w, seen, anys;
  logic [7:0] d0, d1, d2;
  logic [7:0] ed [3]; // Expected DMA status registers
  logic [71:0] q [$]; // Expected snapshots
  int n_mismatch, samples_checked;
  event look;
  ////////////////////////////////////////
  pes_error_status pes_error_status_i (.clk_i(clk_i), .nrst_i(nrst_i),
    .pcix_mode_i(pcix), .direct_port_access_mode_i(direct_port_access_mode),
    .split_completion_error_enable_i(split_completion_error_enable), .ide_chan_sel_i(isel),
    .ob_wr_watch_i(wwatch), .ob_wr_msi_i(wmsi), .ib_wr_perr_i(ibp),
    .scm_perr_i(scm), .ob_rd_mabort_i(mab), .dma_start_i(start),
    .dma_done_i(done), .host_clr_i(hclr), .pcix_clr_i(pclr),
    .dma_err_clr_i(dclr), .perr_n_i(perr_w), .perr_n_o(perr_n),
    .perr_oe_n_o(perr_oe_n), .serr_n_i(serr_w), .serr_n_o(serr_n),
    .serr_oe_n_o(serr_oe_n), .host_status_word_o(host),
    .pcix_status_word_o(pcw), .ide_chan0_dma_status_o(d0),
    .ide_chan1_dma_status_o(d1), .direct_dma_status_o(d2),
    .serr_seen_o(seen));
  pes_bus_agent pes_bus_agent_i (.clk_i(clk_i), .flag_i(flag),
    .dut_perr_n_i(perr_n), .dut_perr_oe_n_i(perr_oe_n),
    .dut_serr_n_i(serr_n), .dut_serr_oe_n_i(serr_oe_n),
    .perr_line_o(perr_w), .serr_line_o(serr_w));
  initial forever #50 clk_i = ~clk_i;
  ////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int sel();
    return direct_port_access_mode ? 2 : int'(isel);
  endfunction
  task automatic step();
    @(posedge clk_i);
    #10;
  endtask
  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic note();
    q.push_back({eh, ep, ed[0], ed[1], ed[2]});
    -> look;
  endtask
  task automatic stop();
    ed[sel()][1:0] = 2'h2;
  endtask
  task automatic wrap_up();
    $display("Checked %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Monitor: compares each appearing result with the oldest note
  initial forever begin
    @(look);
    chk({host, pcw, d0, d1, d2},
      q.pop_front());
  end
  // Driver: random modes, one error kind per pass, then clear
  initial begin
    {pcix, direct_port_access_mode, split_completion_error_enable, isel, wwatch, wmsi, ibp, scm, mab, flag} = '0;
    {start, done, dclr, hclr, pclr} = '0;
    {eh, ep, anys} = '0;
    ed = '{default: 8'h00};
    rnd = 32'h207C2D46;
    repeat (3) @(posedge clk_i);
    #10 nrst_i = 1'b1;
    note();
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      {pcix, direct_port_access_mode, split_completion_error_enable, isel, wmsi} = rnd[4:0];
      start[sel()] = 1'b1;
      ed[sel()][0] = 1'b1;
      step();
      start = '0;
      case (i % 4)
        0: begin
          ibp = 1'b1;
          step();
          ibp = 1'b0;
          eh[15] = 1'b1;
          chk({perr_oe_n, perr_n}, 72'h0);
        end
        1: begin
          scm = 1'b1;
          step();
          scm = 1'b0;
          if (pcix) begin
            eh = eh | 16'hC100;
            ep[29] = split_completion_error_enable;
            anys = 1'b1;
            stop();
          end
          chk(serr_oe_n, !pcix);
        end
        2: begin
          // Clears in the same cycle must lose to the new error
          {mab, hclr, dclr} = '1;
          step();
          {mab, hclr, dclr} = '0;
          eh[13] = 1'b1;
          stop();
          chk({perr_oe_n, serr_oe_n}, 72'h3);
        end
        default: begin
          wwatch = 1'b1;
          flag = 1'b1;
          step();
          {flag, hit, saw} = '0;
          for (int k = 0; k < 8 && !hit; k++) begin
            step();
            saw = saw | !serr_oe_n;
            hit = (host[8] === 1'b1);
          end
          if (!hit) begin
            n_mismatch++;
            wrap_up();
          end
          wwatch = 1'b0;
          eh[8] = 1'b1;
          eh[14] = pcix | wmsi;
          anys = anys | pcix | wmsi;
          stop();
          chk(saw, pcix | wmsi);
        end
      endcase
      step();
      note();
      {hclr, pclr, dclr, done} = '1;
      step();
      {hclr, pclr, dclr, done} = '0;
      {eh, ep} = '0;
      ed = '{default: 8'h00};
      note();
    end
    step();
    chk({seen, serr_n}, {anys, 1'b0});
    // A bus reset in mid-run must wipe a flag that is still set
    mab = 1'b1;
    step();
    mab = 1'b0;
    nrst_i = 1'b0;
    step();
    nrst_i = 1'b1;
    {eh, ep} = '0;
    ed = '{default: 8'h00};
    note();
    // Let the monitor take the last note before the verdict
    step();
    wrap_up();
  end
endmodule // tb_top

`default_nettype wire
